// >>> core/urms_status.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "urms_defines.svh"

module urms_status
	import urms_pkg::*;
#(
	parameter int DEPTH = `URMS_RX_DEPTH
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rstn,
	input  wire logic [`URMS_ADDR_W-1:0]  regAddr,
	input  wire logic [7:0]               regWrData,
	input  wire logic                     regWr,
	input  wire logic                     regRd,
	output logic      [7:0]               regRdData,
	input  wire logic                     rxCharValid,
	input  wire urms_char_s               rxChar,
	input  wire urms_modem_s              modemPinsN,
	output logic                          modemIrq,
	output logic                          irq,
	output logic      [7:0]               extraFeatureCtrl,
	output logic      [7:0]               modemControlReg
);
	localparam int PW = $clog2(DEPTH);

	// ==========================================================
	// Storage and state
	urms_slot_s          rxMem [DEPTH];
	logic [PW-1:0]       wrPtr;
	logic [PW-1:0]       rdPtr;
	logic [PW:0]         count;
	urms_slot_s          holdReg;
	logic                holdFull;
	logic [7:0]          shiftByte;
	logic                overrun;
	logic [7:0]          lineCtrl;
	logic [3:0]          deltaFlags;
	logic [3:0]          pinsPrev;
	logic [3:0]          irqStatus;
	logic [3:0]          irqMask;
	urms_modem_s         pinsSync;

	// ==========================================================
	// Modem input synchroniser
	urms_sync #(
		.W (4)
	) uSync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.din     (modemPinsN),
		.dout    (pinsSync)
	);

	// ==========================================================
	// Address decode
	wire rdLine  = regRd && (regAddr == `URMS_OFF_LINE_STATUS);
	wire rdModem = regRd && (regAddr == `URMS_OFF_MODEM_STAT);
	wire rdData  = regRd && (regAddr == `URMS_OFF_RX_DATA);
	wire wrEfc   = regWr && (regAddr == `URMS_OFF_MODEM_STAT);
	wire wrMc    = regWr && (regAddr == `URMS_OFF_MODEM_CTRL);
	wire wrLc    = regWr && (regAddr == `URMS_OFF_LINE_CTRL);
	wire wrIrqSt = regWr && (regAddr == `URMS_OFF_IRQ_STATUS);
	wire wrIrqMk = regWr && (regAddr == `URMS_OFF_IRQ_MASK);

	// ==========================================================
	// Receive parity check and storage decisions
	wire fifoMode  = lineCtrl[`URMS_LC_FIFO_EN];
	wire parEn     = lineCtrl[`URMS_LC_PAR_EN];
	wire parEven   = lineCtrl[`URMS_LC_PAR_EVEN];
	wire expParity = parEven ? ^rxChar.data : ~(^rxChar.data);
	wire charPErr  = parEn && (rxChar.parityBit != expParity);
	wire fifoFull  = (count == (PW+1)'(DEPTH));
	wire fifoEmpty = (count == '0);
	wire pop       = rdData && fifoMode && !fifoEmpty;
	wire storeFull = fifoMode ? (fifoFull && !pop) : (holdFull && !rdData);
	wire charOvr   = rxCharValid && storeFull;
	wire push      = rxCharValid && fifoMode && !storeFull;

	// Head slot feeds the status bits in FIFO mode
	urms_slot_s headSlot;
	assign headSlot = fifoMode ? rxMem[rdPtr] : holdReg;
	wire hasData    = fifoMode ? !fifoEmpty : holdFull;
	wire headPErr   = hasData && headSlot.parityErr;

	wire [7:0] lineStatus = {5'h00, headPErr, overrun, hasData};

	// ==========================================================
	// Modem status composition
	wire loopback = modemControlReg[`URMS_MC_LOOPBACK];
	wire msCarrier = loopback ? modemControlReg[3] : ~pinsSync.carrierN;
	wire msBell    = loopback ? modemControlReg[2] : ~pinsSync.bellN;
	wire msDsr     = loopback ? modemControlReg[0] : ~pinsSync.dataSetReadyN;
	wire msCts     = loopback ? modemControlReg[1] : ~pinsSync.clearToSendN;
	wire [3:0] levels = {msCarrier, msBell, msDsr, msCts};

	// Change detection on the effective levels
	wire [3:0] changed = levels ^ pinsPrev;
	wire [3:0] setDelta = {changed[3],
		changed[2] && !levels[2],
		changed[1], changed[0]};
	wire [3:0] next_delta = setDelta | (rdModem ? 4'h0 : deltaFlags);

	wire [7:0] modemStatus = {levels, deltaFlags};

	// Sticky interrupt events, set beats clear
	wire [3:0] events = {rxCharValid && !storeFull, charPErr && rxCharValid,
		charOvr, |setDelta};
	wire [3:0] next_irqSt = events | (irqStatus & ~(wrIrqSt ? regWrData[3:0] : 4'h0));

	// ==========================================================
	// Read data mux
	logic [7:0] next_rd;
	always_comb begin
		next_rd = `URMS_RST_BYTE;
		unique case (regAddr)
			`URMS_OFF_RX_DATA:     next_rd = headSlot.data;
			`URMS_OFF_LINE_CTRL:   next_rd = lineCtrl;
			`URMS_OFF_MODEM_CTRL:  next_rd = modemControlReg;
			`URMS_OFF_LINE_STATUS: next_rd = lineStatus;
			`URMS_OFF_MODEM_STAT:  next_rd = modemStatus;
			`URMS_OFF_IRQ_STATUS:  next_rd = {4'h0, irqStatus};
			`URMS_OFF_IRQ_MASK:    next_rd = {4'h0, irqMask};
			default:               next_rd = `URMS_RST_BYTE;
		endcase
	end

	// ==========================================================
	// Register port and control registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			regRdData        <= `URMS_RST_BYTE;
			lineCtrl         <= `URMS_RST_BYTE;
			modemControlReg  <= `URMS_RST_BYTE;
			extraFeatureCtrl <= `URMS_RST_BYTE;
			irqMask          <= 4'h0;
		end else begin
			regRdData <= regRd ? next_rd : `URMS_RST_BYTE;
			if (wrLc) begin
				lineCtrl <= regWrData;
			end
			if (wrMc) begin
				modemControlReg <= regWrData;
			end
			if (wrEfc) begin
				extraFeatureCtrl <= regWrData;
			end
			if (wrIrqMk) begin
				irqMask <= regWrData[3:0];
			end
		end
	end

	// ==========================================================
	// Receive FIFO pointers and count
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Receive FIFO memory, no reset needed
	always_ff @(posedge ref_clk) begin
		if (push) begin
			rxMem[wrPtr] <= '{data: rxChar.data, parityErr: charPErr};
		end
	end

	// ==========================================================
	// Holding register, shift byte and overrun flag
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			holdReg   <= '0;
			holdFull  <= 1'b0;
			shiftByte <= `URMS_RST_BYTE;
			overrun   <= 1'b0;
		end else begin
			if (rxCharValid) begin
				shiftByte <= rxChar.data;
			end
			if (rxCharValid && !fifoMode && !storeFull) begin
				holdReg  <= '{data: rxChar.data, parityErr: charPErr};
				holdFull <= 1'b1;
			end else if (rdData && !fifoMode) begin
				holdFull <= 1'b0;
			end
			overrun <= charOvr | (overrun & ~rdLine);
		end
	end

	// ==========================================================
	// Modem change flags and interrupts
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pinsPrev   <= 4'h0;
			deltaFlags <= 4'h0;
			irqStatus  <= 4'h0;
			modemIrq   <= 1'b0;
			irq        <= 1'b0;
		end else begin
			pinsPrev   <= levels;
			deltaFlags <= next_delta;
			irqStatus  <= next_irqSt;
			modemIrq   <= |next_delta;
			irq        <= |(next_irqSt & irqMask);
		end
	end
endmodule

// >>> core/urms_defines.svh
`ifndef URMS_DEFINES_SVH
`define URMS_DEFINES_SVH

// ==========================================================
// Register offsets, plain port addresses
`define URMS_ADDR_W          4
`define URMS_OFF_LINE_STATUS 4'h5
`define URMS_OFF_MODEM_STAT  4'h6
`define URMS_OFF_MODEM_CTRL  4'h4
`define URMS_OFF_LINE_CTRL   4'h3
`define URMS_OFF_RX_DATA     4'h0
`define URMS_OFF_IRQ_STATUS  4'h8
`define URMS_OFF_IRQ_MASK    4'h9

// ==========================================================
// Field positions
`define URMS_LS_READY        0
`define URMS_LS_OVERRUN      1
`define URMS_LS_PARITY       2
`define URMS_MC_LOOPBACK     4
`define URMS_LC_PAR_EN       3
`define URMS_LC_PAR_EVEN     4
`define URMS_LC_FIFO_EN      0
`define URMS_IRQ_MODEM       0
`define URMS_IRQ_OVERRUN     1
`define URMS_IRQ_PARITY      2
`define URMS_IRQ_READY       3

// ==========================================================
// Reset values and receive FIFO depth
`define URMS_RST_BYTE        8'h00
`define URMS_RST_PINS        4'hf
`define URMS_RX_DEPTH        16

`endif

// >>> core/urms_pkg.sv
package urms_pkg;
	// Received character as delivered by the deserialiser
	typedef struct packed {
		logic [7:0] data;
		logic       parityBit;
	} urms_char_s;

	// Modem input levels, active low at the pins
	typedef struct packed {
		logic carrierN;
		logic bellN;
		logic dataSetReadyN;
		logic clearToSendN;
	} urms_modem_s;

	// Receive slot with its own parity error flag
	typedef struct packed {
		logic [7:0] data;
		logic       parityErr;
	} urms_slot_s;
endpackage

// >>> core/urms_sync.sv
`timescale 1ns/1ns
`include "urms_defines.svh"

// Three-stage synchroniser; output moves when stages two and three agree
module urms_sync #(
	parameter int W = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire  [W-1:0] agree;

	// ==========================================================
	// Per bit stages
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : gBit
			assign agree[i] = ~(s2[i] ^ s3[i]);
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					s1[i]   <= 1'b1;
					s2[i]   <= 1'b1;
					s3[i]   <= 1'b1;
					dout[i] <= 1'b1;
				end else begin
					s1[i] <= din[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (agree[i]) begin
						dout[i] <= s3[i];
					end
				end
			end
		end
	endgenerate
endmodule

// >>> verification/urms_modem_model.sv
`timescale 1ns/1ns
// ==========
// Modem side of the status block
module urms_modem_model
	import urms_pkg::*;
(
	input wire logic  ref_clk,
	output urms_modem_s pinsN
);
	// Pins idle inactive high; no duty falls on this side
	initial pinsN = 4'hf;
	// One pin moves at a falling edge, away from the sampling edge
	task automatic setPin(input int i, input logic v);
		@(negedge ref_clk);
		pinsN[i] = v;
	endtask
endmodule

// >>> verification/urms_status_assertions.sv
`timescale 1ns/1ns
`include "urms_defines.svh"
// ==========
// Port checker
module urms_status_assertions (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdData,
	input wire logic       modemIrq,
	input wire logic       irq,
	input wire logic [7:0] extraFeatureCtrl,
	input wire logic [7:0] modemControlReg
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// Decoded accesses and loopback level order
	wire       msRd    = regRd && regAddr == `URMS_OFF_MODEM_STAT;
	wire       msWr    = regWr && regAddr == `URMS_OFF_MODEM_STAT;
	wire       isRd    = regRd && regAddr == `URMS_OFF_IRQ_STATUS;
	wire [3:0] loopLvl = {modemControlReg[3:2], modemControlReg[0], modemControlReg[1]};
	// Loopback read after the control bits have settled
	sequence s_mcQuiet;
		$stable(modemControlReg) [*8];
	endsequence
	sequence s_loopRd;
		msRd && modemControlReg[`URMS_MC_LOOPBACK];
	endsequence
	property p_loop;
		s_mcQuiet ##0 s_loopRd |=> regRdData[7:4] == $past(loopLvl);
	endproperty
	a_loop: assert property (p_loop)
		else $error("loopback levels wrong");
	property p_irqFlags; msRd && modemIrq |=> regRdData[3:0] != 4'h0; endproperty
	a_irqFlags: assert property (p_irqFlags)
		else $error("modem irq without flags");
	property p_flagsZero; msRd && !modemIrq |=> regRdData[3:0] == 4'h0; endproperty
	a_flagsZero: assert property (p_flagsZero)
		else $error("flags set without modem irq");
	property p_irqFall; $fell(modemIrq) |-> $past(msRd); endproperty
	a_irqFall: assert property (p_irqFall)
		else $error("modem irq fell without read");
	property p_efcWr; msWr |=> extraFeatureCtrl == $past(regWrData); endproperty
	a_efcWr: assert property (p_efcWr)
		else $error("feature control not written");
	property p_mcKept; msWr |=> $stable(modemControlReg); endproperty
	a_mcKept: assert property (p_mcKept)
		else $error("modem control hit by write");
	property p_rdIdle; !regRd |=> regRdData == 8'h00; endproperty
	a_rdIdle: assert property (p_rdIdle)
		else $error("read data outside read");
	property p_irqStat; isRd && irq && !$past(regWr) |=> regRdData != 8'h00; endproperty
	a_irqStat: assert property (p_irqStat)
		else $error("irq with empty status");
endmodule

bind urms_status urms_status_assertions chk (.*);

// >>> verification/urms_status_tb.sv
`timescale 1ns/1ns
// ==========
// Self-checking bench
module urms_status_tb
	import urms_pkg::*;
;
	localparam int DEPTH = 4;
	logic        ref_clk = 0;
	logic        rstn = 0;
	logic        regWr = 0;
	logic        regRd = 0;
	logic        rxCharValid = 0;
	logic [3:0]  regAddr = 0;
	logic [7:0]  regWrData = 0;
	logic [7:0]  regRdData;
	logic [7:0]  extraFeatureCtrl;
	logic [7:0]  modemControlReg;
	logic        modemIrq;
	logic        irq;
	urms_char_s  rxChar = '0;
	urms_modem_s modemPinsN;
	int          fail_count = 0;
	int          samples_checked = 0;

	urms_status #(.DEPTH(DEPTH)) dut (.*);
	urms_modem_model mdm (.ref_clk(ref_clk), .pinsN(modemPinsN));

	// ==========
	// Access tasks
	task automatic chk(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1;
		@(posedge ref_clk);
		regWr <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, m = 8'hff);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1;
		@(posedge ref_clk);
		regRd <= 0;
		#1 chk(regRdData & m, exp);
	endtask
	task automatic rx(input logic [7:0] v, input logic p);
		@(posedge ref_clk);
		rxChar <= '{v, p};
		rxCharValid <= 1;
		@(posedge ref_clk);
		rxCharValid <= 0;
	endtask
	task automatic pause;
		repeat (10) @(posedge ref_clk);
		#1;
	endtask
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Clock and watchdog
	initial forever #2 ref_clk = ~ref_clk;
	initial begin
		#100000;
		fail_count++;
		end_of_test;
	end

	// ==========
	// Tests
	initial begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1;
		rd(5, 0);
		rd(6, 0);
		rd(4'hf, 0);
		wr(4, 8'h03);
		wr(6, 8'h5a);
		#1 chk(extraFeatureCtrl, 8'h5a);
		chk(modemControlReg, 8'h03);
		rd(6, 0, 8'hf0);
		wr(4, 0);
		$display("shared address done");
		for (int i = 0; i < 4; i++) begin
			mdm.setPin(i, 0);
			pause;
			chk({7'h0, modemIrq}, {7'h0, i != 2});
			rd(6, (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i));
			rd(6, 8'h10 << i);
			mdm.setPin(i, 1);
			pause;
			rd(6, 8'h01 << i);
			rd(6, 0);
		end
		$display("modem inputs done");
		wr(4, 8'h15);
		pause;
		rd(6, 8'h60, 8'hf0);
		wr(4, 8'h1a);
		pause;
		rd(6, 8'h90, 8'hf0);
		wr(4, 0);
		pause;
		rd(6, 0, 8'hf0);
		$display("loopback done");
		wr(3, 8'h18);
		rx(8'h01, 1);
		rd(5, 8'h01);
		rd(0, 8'h01);
		rd(5, 0);
		rx(8'h03, 1);
		rd(5, 8'h05);
		rd(0, 8'h03);
		wr(3, 8'h19);
		rx(8'h01, 1);
		rx(8'h03, 1);
		rd(5, 8'h01);
		rd(0, 8'h01);
		rd(5, 8'h05);
		rd(0, 8'h03);
		for (int i = 0; i < DEPTH; i++)
			rx(8'(i), ^8'(i));
		rx(8'hee, 0);
		rd(5, 8'h03);
		rd(5, 8'h01);
		for (int i = 0; i < DEPTH; i++)
			rd(0, 8'(i));
		rd(5, 0);
		$display("receive status done");
		wr(8, 8'hff);
		rd(8, 0);
		wr(9, 8'h08);
		rx(8'h01, 1);
		pause;
		chk({7'h0, irq}, 8'h01);
		rd(8, 8'h08);
		wr(9, 0);
		pause;
		chk({7'h0, irq}, 8'h00);
		wr(9, 8'h08);
		wr(8, 8'h08);
		pause;
		chk({7'h0, irq}, 8'h00);
		rd(8, 0);
		$display("interrupts done");
		end_of_test;
	end
endmodule
